/* File: core/tpc_pkg.sv */
/*
  Constants, field layouts, reset values and types for the test pattern
  element combiner. Assumes a 125 MHz pixel clock.
*/
package tpc_pkg;
  localparam int CLK_NS          = 8;
  localparam int ACT_LINE_NS     = 42400;
  localparam int ACT_LINE_CYC    = ACT_LINE_NS / CLK_NS;
  localparam int STRIPE_MIN_NS   = 7000;
  localparam int STRIPE_MIN_CYC  = (STRIPE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRIPE_X_CYC    = ACT_LINE_CYC / 4;
  localparam int STRIPE_W_CYC    = ACT_LINE_CYC / 2;
  localparam int COL_W_NS        = 100;
  localparam int COL_W_CYC       = (COL_W_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_SPACE_PPM   = 60500;
  localparam int COL_SPACE_CYC   = ACT_LINE_CYC * COL_SPACE_PPM / 1000000;
  localparam int FIELD_LINES     = 338;
  localparam int ROW_INTERVALS   = 15;
  localparam int ROW_SPACE_LINES = FIELD_LINES / ROW_INTERVALS;
  localparam int H_ACT_START     = 200;
  localparam int V_ACT_START     = 20;
  localparam int V_ACT_LINES     = 300;
  localparam int HW              = 13;
  localparam int VW              = 10;
  localparam int AW              = 8;
  localparam int NREG            = 7;
  localparam int FIFO_DEPTH      = 16;
  localparam int PIX_W           = 9;
  localparam logic [3:0] LEVEL_MAX  = 4'ha;
  localparam logic [7:0] LEVEL_STEP = 8'h19;
  localparam int CTRL_POL_BIT    = 4;
  localparam int CTRL_LVL_LSB    = 8;
  localparam int IDX_CTRL        = 0;
  localparam int IDX_STRIPE      = 4;
  localparam int IDX_STATUS      = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FN_COLS   = 3'h0,
    FN_ROWS   = 3'h1,
    FN_GRID   = 3'h3,
    FN_DOTS   = 3'h2,
    FN_STRIPE = 3'h6
  } tpc_func_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RESP = 2'h1
  } tpc_bus_e;

  function automatic logic [31:0] tpc_pk(int hi, int lo);
    return {3'h0, 13'(hi), 3'h0, 13'(lo)};
  endfunction: tpc_pk

  localparam logic [NREG-1:0][31:0] RST_REGS = {
    tpc_pk(V_ACT_LINES, V_ACT_START),
    tpc_pk(ACT_LINE_CYC, H_ACT_START),
    tpc_pk(STRIPE_W_CYC, STRIPE_X_CYC),
    tpc_pk(0, ROW_SPACE_LINES),
    tpc_pk(0, COL_W_CYC),
    tpc_pk(0, COL_SPACE_CYC),
    {20'h00000, LEVEL_MAX, 8'h00}};
  localparam logic [NREG-1:0][31:0] REG_MASK = {
    32'h03ff_03ff, 32'h1fff_1fff, 32'h1fff_1fff, 32'h03ff_03ff,
    32'h0000_1fff, 32'h1fff_1fff, 32'h0000_0f17};
endpackage: tpc_pkg

/* File: core/tpc_fifo_if.sv */
/*
  Valid/ready carrier between the combiner and its output FIFO.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface tpc_fifo_if #(parameter int W = 9);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport src  (output in_valid, in_data, input in_ready);
  modport snk  (input out_valid, out_data, output out_ready);
endinterface: tpc_fifo_if

/* File: core/tpc_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes power-of-two depth; state frozen while ce is low.
*/
`timescale 1ns/1ps
module tpc_fifo
  import tpc_pkg::*;
#(
  parameter int W     = PIX_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  tpc_fifo_if.fifo f
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } tpc_fifo_s;

  tpc_fifo_s st;
  tpc_fifo_s next_st;
  logic      push;
  logic      pop;

  // handshakes are gated by ce so a frozen fifo never looks ready
  assign f.in_ready  = ce && (st.cnt < CW'(DEPTH));
  assign f.out_valid = ce && (st.cnt != '0);
  assign f.out_data  = st.mem[st.rp];
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = f.in_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    if (srst)
      next_st = '0;
  end

  always_ff @(posedge clk)
    if (srst || ce)
      st <= next_st;
endmodule: tpc_fifo

/* File: core/tpc_combiner.sv */
/*
  Test pattern element combiner: column/row elements, grid, crosspoint
  and centred stripe, polarity and level, AXI4-Lite register slave and a
  16-word output FIFO. Assumes line and field drive arrive asynchronously
  as active-high pulses at least three clocks long.
  // Function
  // - white polarity: bright elements on black; black: dark on white
  // - polarity swaps brightness only, timing and geometry unchanged
  // - grid output is union of column and row elements
  // - crosspoint output lit only where column and row coincide
  // - grid columns reuse column spacing, width and position settings
  // - grid rows reuse row spacing and position settings
  // - dot width follows column width; positions follow grid settings
  // - stripe starts after quarter active line left margin
  // - stripe width programmable from 7.0 us, nominal half line
  // - nominal settings leave quarter line after stripe, centring it
  // - stripe clipped to active line on extreme settings
  // - level 0..10 scales active content only; blanking stays fixed
  // - columns every 0.0605 active line, about 0.10 us wide
  // - rows split field into 15, each one whole scan line
*/
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module tpc_combiner
  import tpc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          line_drive,
  input  wire logic          field_drive,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               vid_valid,
  input  wire logic          vid_ready,
  output logic [7:0]         vid_data,
  output logic               vid_active
);
  typedef struct packed {
    logic [2:0]             ld_s;
    logic [2:0]             fd_s;
    logic                   ld_st;
    logic                   fd_st;
    logic                   ld_pend;
    logic                   fd_pend;
    logic [HW-1:0]          hcnt;
    logic [HW-1:0]          cph;
    logic [VW-1:0]          vcnt;
    logic [VW-1:0]          rph;
    tpc_func_e              func_q;
    logic [NREG-1:0][31:0]  regs;
    tpc_bus_e               wst;
    tpc_bus_e               rst_q;
    logic                   aw_got;
    logic                   w_got;
    logic [AW-1:0]          awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } tpc_state_s;
  tpc_state_s    st;
  tpc_state_s    next_st;
  logic          adv;
  logic          ld_rise;
  logic          fd_rise;
  logic          ln_ev;
  logic          fl_ev;
  logic          h_act;
  logic          v_act;
  logic          hv_act;
  logic          col_on;
  logic          row_on;
  logic          stripe_on;
  logic          sel;
  logic          elem;
  logic          pix;
  logic          pol;
  logic [HW-1:0] hrel;
  logic [VW-1:0] vrel;
  logic [7:0]    lvl_val;
  logic [7:0]    vid;
  logic [HW-1:0] col_sp;
  logic [HW-1:0] col_off;
  logic [HW-1:0] col_w;
  logic [VW-1:0] row_sp;
  logic [VW-1:0] row_off;
  logic [HW-1:0] sx;
  logic [HW-1:0] sw;
  logic [HW-1:0] hstart;
  logic [HW-1:0] hlen;
  logic [VW-1:0] vstart;
  logic [VW-1:0] vlen;
  logic [3:0]    wdec;
  logic [3:0]    rdec;
  logic          aw_hs;
  logic          w_hs;
  logic          ar_hs;
  tpc_fifo_if #(.W(PIX_W)) fq ();
  // {hit, index}: aligned word inside the map, status included
  function automatic logic [3:0] reg_dec(input logic [AW-1:0] a);
    logic [5:0] w;
    w = a[AW-1:2];
    if (a[1:0] == 2'h0 && w <= 6'(IDX_STATUS))
      return {1'b1, w[2:0]};
    return 4'h0;
  endfunction: reg_dec
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction: merge
  // one setting per field, shared by every function that reads that field
  assign col_sp  = st.regs[1][HW-1:0];
  assign col_off = st.regs[1][16 +: HW];
  assign col_w   = st.regs[2][HW-1:0];
  assign row_sp  = st.regs[3][VW-1:0];
  assign row_off = st.regs[3][16 +: VW];
  assign sx      = st.regs[IDX_STRIPE][HW-1:0];
  assign sw      = st.regs[IDX_STRIPE][16 +: HW];
  assign hstart  = st.regs[5][HW-1:0];
  assign hlen    = st.regs[5][16 +: HW];
  assign vstart  = st.regs[6][VW-1:0];
  assign vlen    = st.regs[6][16 +: VW];
  assign pol     = st.regs[IDX_CTRL][CTRL_POL_BIT];
  // a stalled output holds the pixel; drive edges wait as pending
  assign adv     = ce && fq.in_ready;
  assign ld_rise = st.ld_s[2] && st.ld_s[1] && !st.ld_st;
  assign fd_rise = st.fd_s[2] && st.fd_s[1] && !st.fd_st;
  assign ln_ev   = ld_rise || st.ld_pend;
  assign fl_ev   = fd_rise || st.fd_pend;
  assign hrel   = st.hcnt - hstart;
  assign vrel   = st.vcnt - vstart;
  assign h_act  = (st.hcnt >= hstart) && (hrel < hlen);
  assign v_act  = (st.vcnt >= vstart) && (vrel < vlen);
  assign hv_act = h_act && v_act;
  // column element lit for col_w clocks of each period
  assign col_on = st.cph < col_w;
  // row phase steps per line, so a row lights a whole line
  assign row_on = st.rph == '0;
  // stripe measured from active start, clipped by h_act
  assign stripe_on = (hrel >= sx) && ((hrel - sx) < sw);
  always_comb
  begin
    case (st.func_q)
      FN_COLS:   sel = col_on;
      FN_ROWS:   sel = row_on;
      FN_GRID:   sel = col_on || row_on;
      FN_DOTS:   sel = col_on && row_on;
      FN_STRIPE: sel = stripe_on;
      default:   sel = 1'b0;
    endcase
  end
  // background outside active area, ahead of polarity
  assign elem    = hv_act && sel;
  assign pix     = elem ^ pol;
  assign lvl_val = 8'(st.regs[IDX_CTRL][CTRL_LVL_LSB +: 4]) * LEVEL_STEP;
  // level scales active video; blanking held at zero
  assign vid     = (hv_act && pix) ? lvl_val : 8'h00;
  assign fq.in_valid  = ce && !srst;
  assign fq.in_data   = {hv_act, vid};
  assign fq.out_ready = vid_ready;
  assign vid_valid    = fq.out_valid;
  assign vid_data     = fq.out_data[7:0];
  assign vid_active   = fq.out_data[8];
  tpc_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .f    (fq)
  );
  assign s_axi_awready = ce && !st.aw_got && st.wst == BUS_IDLE;
  assign s_axi_wready  = ce && !st.w_got && st.wst == BUS_IDLE;
  assign s_axi_bvalid  = st.wst == BUS_RESP;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = ce && st.rst_q == BUS_IDLE;
  assign s_axi_rvalid  = st.rst_q == BUS_RESP;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wdec  = reg_dec(st.awaddr);
  assign rdec  = reg_dec(s_axi_araddr);
  always_comb
  begin
    logic [31:0] wv;
    wv = 32'h0;
    next_st = st;
    // stages two and three feed logic; stage one feeds stage two only
    next_st.ld_s = {st.ld_s[1:0], line_drive};
    next_st.fd_s = {st.fd_s[1:0], field_drive};
    if (st.ld_s[2] == st.ld_s[1])
      next_st.ld_st = st.ld_s[2];
    if (st.fd_s[2] == st.fd_s[1])
      next_st.fd_st = st.fd_s[2];
    if (adv)
    begin
      next_st.ld_pend = 1'b0;
      next_st.fd_pend = 1'b0;
      // counters restarted by the drive references
      if (ln_ev)
      begin
        next_st.hcnt = '0;
        next_st.cph  = col_off;
      end
      else
      begin
        if (st.hcnt != '1)
          next_st.hcnt = st.hcnt + 1'b1;
        // column period from the spacing setting
        if (st.hcnt >= hstart)
          next_st.cph = (st.cph + 1'b1 >= col_sp) ? '0 : st.cph + 1'b1;
      end
      if (fl_ev)
      begin
        next_st.vcnt   = '0;
        next_st.rph    = row_off;
        next_st.func_q = tpc_func_e'(st.regs[IDX_CTRL][2:0]);
      end
      else if (ln_ev)
      begin
        if (st.vcnt != '1)
          next_st.vcnt = st.vcnt + 1'b1;
        // row interval counted in whole lines
        if (st.vcnt >= vstart)
          next_st.rph = (st.rph + 1'b1 >= row_sp) ? '0 : st.rph + 1'b1;
      end
    end
    else
    begin
      next_st.ld_pend = st.ld_pend || ld_rise;
      next_st.fd_pend = st.fd_pend || fd_rise;
    end
    if (aw_hs)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    case (st.wst)
      BUS_IDLE:
        if (st.aw_got && st.w_got)
        begin
          next_st.aw_got = 1'b0;
          next_st.w_got  = 1'b0;
          next_st.wst    = BUS_RESP;
          next_st.bresp  = RESP_SLVERR;
          if (wdec[3] && wdec[2:0] != 3'(IDX_STATUS))
          begin
            next_st.bresp = RESP_OKAY;
            wv = merge(st.regs[wdec[2:0]], st.wdata, st.wstrb)
                 & REG_MASK[wdec[2:0]];
            if (wdec[2:0] == 3'(IDX_CTRL)
                && wv[CTRL_LVL_LSB +: 4] > LEVEL_MAX)
              wv[CTRL_LVL_LSB +: 4] = LEVEL_MAX;
            // stripe width never below the minimum
            if (wdec[2:0] == 3'(IDX_STRIPE)
                && wv[16 +: HW] < HW'(STRIPE_MIN_CYC))
              wv[16 +: HW] = HW'(STRIPE_MIN_CYC);
            next_st.regs[wdec[2:0]] = wv;
          end
        end
      BUS_RESP:
        if (s_axi_bready)
          next_st.wst = BUS_IDLE;
      default:
        next_st.wst = BUS_IDLE;
    endcase
    case (st.rst_q)
      BUS_IDLE:
        if (ar_hs)
        begin
          next_st.rst_q = BUS_RESP;
          next_st.rresp = rdec[3] ? RESP_OKAY : RESP_SLVERR;
          if (!rdec[3])
            next_st.rdata = 32'h0;
          else if (rdec[2:0] == 3'(IDX_STATUS))
            next_st.rdata = {7'h00, pol, 5'h00, st.func_q, 6'h00,
                             st.vcnt};
          else
            next_st.rdata = st.regs[rdec[2:0]];
        end
      BUS_RESP:
        if (s_axi_rready)
          next_st.rst_q = BUS_IDLE;
      default:
        next_st.rst_q = BUS_IDLE;
    endcase
    if (srst)
    begin
      next_st        = '0;
      next_st.regs   = RST_REGS;
      next_st.func_q = FN_COLS;
    end
  end
  always_ff @(posedge clk)
    if (srst || ce)
      st <= next_st;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_white_level: assert property (
    adv && hv_act && elem && !pol |-> fq.in_data[7:0] == lvl_val)
    else $error("white element not at level");
  chk_black_invert: assert property (
    adv && elem && pol |-> fq.in_data[7:0] == 8'h00)
    else $error("black element not dark");
  chk_grid_union: assert property (
    st.func_q == FN_GRID && hv_act && (col_on || row_on) |-> elem)
    else $error("grid element missing");
  chk_dot_coincide: assert property (
    st.func_q == FN_DOTS && elem |-> col_on && row_on)
    else $error("dot outside crosspoint");
  chk_stripe_margin: assert property (
    st.func_q == FN_STRIPE && hrel < sx |-> !elem)
    else $error("stripe inside left margin");
  chk_stripe_minw: assert property (
    sw >= HW'(STRIPE_MIN_CYC))
    else $error("stripe width below minimum");
  chk_row_whole: assert property (
    ce && !srst && !ln_ev && !fl_ev |=> $stable(st.rph))
    else $error("row phase moved mid line");
  chk_func_field: assert property (
    ce && !fl_ev |=> $stable(st.func_q))
    else $error("function changed outside field start");
  chk_blank_bg: assert property (
    adv && !hv_act |-> fq.in_data == '0)
    else $error("blanking not at background");
  chk_level_span: assert property (
    adv && hv_act |-> fq.in_data[7:0] <= 8'(LEVEL_MAX) * LEVEL_STEP)
    else $error("video above full level");
  cov_grid: cover property (adv && elem && st.func_q == FN_GRID);
  cov_dots: cover property (adv && elem && st.func_q == FN_DOTS);
  cov_stripe_black: cover property (adv && hv_act && stripe_on && pol
                                    && st.func_q == FN_STRIPE);
  cov_fifo_full: cover property (ce && !fq.in_ready);
endmodule: tpc_combiner

/* File: tb/tpc_sink.sv */
/*
  Pixel sink standing in for the monitor at the far end of the stream.
  Assumes one clock shared with the combiner.
*/
`timescale 1ns/1ps
module tpc_sink
(
  input  wire logic       clk,
  input  wire logic       vid_valid,
  input  wire logic [7:0] vid_data,
  input  wire logic       vid_active,
  output logic            vid_ready,
  input  wire logic       arm,
  input  wire logic       slow,
  input  wire logic       hold
);
  logic [7:0] act_q[$];
  int         blank_bad = 0;
  int         stand_bad = 0;
  int         n = 0;
  logic [8:0] held = '0;
  logic       wait_pix = 1'b0;

  initial vid_ready = 1'b0;

  always @(posedge clk)
  begin
    n <= n + 1;
    // a refused pixel must stand unchanged until it is taken
    if (wait_pix && (!vid_valid || {vid_active, vid_data} !== held))
      stand_bad <= stand_bad + 1;
    wait_pix <= vid_valid && !vid_ready;
    held     <= {vid_active, vid_data};
    if (vid_valid && vid_ready)
    begin
      if (!vid_active && vid_data !== 8'h00)
        blank_bad <= blank_bad + 1;
      if (arm && vid_active)
        act_q.push_back(vid_data);
    end
    // slow mode refuses one pixel in four, hold refuses all
    vid_ready <= !hold && !(slow && n[1:0] == 2'h3);
  end
endmodule: tpc_sink

/* File: tb/tb.sv */
/*
  Self-checking bench: register access over AXI4-Lite, whole fields
  captured through the sink and compared. Assumes tpc_pkg, tpc_sink.
*/
`timescale 1ns/1ps
module tb
  import tpc_pkg::*;
;
  typedef logic [7:0] tpc_pix_t[$];
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic          line_drive = 1'b0;
  logic          field_drive = 1'b0;
  logic [AW-1:0] awaddr = '0;
  logic          awvalid = 1'b0;
  logic          awready;
  logic [31:0]   wdata = '0;
  logic          wvalid = 1'b0;
  logic          wready;
  logic [1:0]    bresp;
  logic          bvalid;
  logic          bready = 1'b0;
  logic [AW-1:0] araddr = '0;
  logic          arvalid = 1'b0;
  logic          arready;
  logic [31:0]   rdata;
  logic [1:0]    rresp;
  logic          rvalid;
  logic          rready = 1'b0;
  logic          vid_valid;
  logic          vid_ready;
  logic [7:0]    vid_data;
  logic          vid_active;
  logic          arm = 1'b0;
  logic          slow = 1'b0;
  logic          hold = 1'b0;
  logic          ce = 1'b1;
  logic [3:0]    wstrb = 4'hf;
  int            miscompares = 0;
  int            checked = 0;

  tpc_combiner dut (
    .clk(clk), .srst(srst), .ce(ce),
    .line_drive(line_drive), .field_drive(field_drive),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vid_valid(vid_valid), .vid_ready(vid_ready),
    .vid_data(vid_data), .vid_active(vid_active));

  tpc_sink sink (
    .clk(clk), .vid_valid(vid_valid), .vid_data(vid_data),
    .vid_active(vid_active), .vid_ready(vid_ready),
    .arm(arm), .slow(slow), .hold(hold));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic results();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask: results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask: check

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask: cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 200)
    begin
      miscompares++;
      results();
    end
  endtask: wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 200)
    begin
      miscompares++;
      results();
    end
  endtask: rd

  task automatic pulse(input bit fld);
    if (fld)
      field_drive <= 1'b1;
    else
      line_drive <= 1'b1;
    cyc(4);
    field_drive <= 1'b0;
    line_drive  <= 1'b0;
  endtask: pulse

  // a spare field pulse comes first; the second pulse latches the function for the captured one
  task automatic field(input int lines, input int per, input bit mid,
                       input logic [31:0] mv, output tpc_pix_t q);
    logic [1:0] r;
    pulse(1'b1);
    cyc(20);
    pulse(1'b1);
    sink.act_q.delete();
    arm <= 1'b1;
    if (mid)
      wr(8'h00, mv, r);
    cyc(per);
    repeat (lines - 1)
    begin
      pulse(1'b0);
      cyc(per);
    end
    pulse(1'b0);
    cyc(40);
    arm <= 1'b0;
    q = sink.act_q;
  endtask: field

  task automatic cap(input logic [31:0] ctl, output tpc_pix_t q);
    logic [1:0] r;
    wr(8'h00, ctl, r);
    field(8, 120, 1'b0, 32'h0, q);
  endtask: cap

  function automatic int lit(tpc_pix_t q);
    int n;
    n = 0;
    foreach (q[i])
      n += (q[i] === 8'hfa);
    return n;
  endfunction: lit

  // op 0: a or b lit, 1: a and b lit, else a inverted
  function automatic int diff(tpc_pix_t g, tpc_pix_t a, tpc_pix_t b,
                              int op, logic [7:0] lv);
    int         bad;
    logic [7:0] e;
    bad = 0;
    if (g.size() != a.size() || g.size() != b.size())
      return -1;
    foreach (g[i])
    begin
      case (op)
        0: e = (a[i] !== 8'h00 || b[i] !== 8'h00) ? lv : 8'h00;
        1: e = (a[i] !== 8'h00 && b[i] !== 8'h00) ? lv : 8'h00;
        default: e = (a[i] !== 8'h00) ? 8'h00 : lv;
      endcase
      bad += (g[i] !== e);
    end
    return bad;
  endfunction: diff

  function automatic int stripe(tpc_pix_t q, int a, int b);
    int bad;
    bad = (q.size() != ACT_LINE_CYC);
    foreach (q[i])
      bad += (q[i] !== ((i >= a && i < b) ? 8'hfa : 8'h00));
    return bad;
  endfunction: stripe

  initial
  begin
    tpc_pix_t    c;
    tpc_pix_t    rw;
    tpc_pix_t    x;
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < NREG; i++)
    begin
      rd(8'(4 * i), d, r);
      check(d, RST_REGS[i], "reset value");
    end
    rd(8'h20, d, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped read");
    check(d, 32'h0, "unmapped data");
    wr(8'h1c, 32'hffffffff, r);
    check(32'(r), 32'(RESP_SLVERR), "status write");
    wr(8'h08, 32'hffffffff, r);
    rd(8'h08, d, r);
    check(d, 32'h0000_1fff, "reserved bits");
    wstrb <= 4'h2;
    wr(8'h08, 32'h0000_0000, r);
    wstrb <= 4'hf;
    rd(8'h08, d, r);
    check(d, 32'h0000_00ff, "byte strobe");
    $display("test registers done");
    wr(8'h08, 32'h0000_0003, r);
    wr(8'h18, 32'h0001_0001, r);
    wr(8'h00, 32'h0000_0a06, r);
    field(2, 5560, 1'b0, 32'h0, x);
    check(stripe(x, ACT_LINE_CYC / 4, ACT_LINE_CYC * 3 / 4), 0,
          "nominal stripe");
    wr(8'h10, 32'h0064_03e8, r);
    field(2, 5560, 1'b0, 32'h0, x);
    check(stripe(x, 1000, 1000 + STRIPE_MIN_CYC), 0, "min width");
    wr(8'h10, 32'h036b_12c0, r);
    field(2, 5560, 1'b0, 32'h0, x);
    check(stripe(x, 4800, ACT_LINE_CYC), 0, "clipped stripe");
    $display("test stripe done");
    wr(8'h14, 32'h0040_0008, r);
    wr(8'h18, 32'h0006_0002, r);
    wr(8'h04, 32'h0000_0008, r);
    wr(8'h0c, 32'h0000_0003, r);
    cap(32'h0000_0a00, c);
    check(c.size(), 6 * 64, "active area");
    check(lit(c), 6 * 64 * 3 / 8, "columns");
    cap(32'h0000_0a01, rw);
    check(lit(rw), 2 * 64, "rows");
    check(diff(rw, rw, rw, 0, 8'hfa), 0, "row levels");
    foreach (rw[i])
      check(rw[i], rw[i - i % 64], "whole lines");
    cap(32'h0000_0a03, x);
    check(diff(x, c, rw, 0, 8'hfa), 0, "grid");
    cap(32'h0000_0a02, x);
    check(diff(x, c, rw, 1, 8'hfa), 0, "dots");
    cap(32'h0000_0a10, x);
    check(diff(x, c, c, 2, 8'hfa), 0, "black");
    cap(32'h0000_0400, x);
    check(diff(x, c, c, 0, 8'h64), 0, "level four");
    wr(8'h00, 32'h0000_0a01, r);
    field(8, 120, 1'b1, 32'h0000_0a00, x);
    check(diff(x, rw, rw, 0, 8'hfa), 0, "mid-field select");
    slow <= 1'b1;
    cap(32'h0000_0a03, x);
    slow <= 1'b0;
    check(diff(x, c, rw, 0, 8'hfa), 0, "slow sink grid");
    rd(8'h1c, d, r);
    check(d, 32'h0003_0008, "status");
    wr(8'h08, 32'h0000_0002, r);
    cap(32'h0000_0a02, x);
    check(lit(x), 6 * 8 * 2 * 2 / 6, "narrow dots");
    $display("test patterns done");
    hold <= 1'b1;
    cyc(40);
    hold <= 1'b0;
    cyc(40);
    check(sink.stand_bad, 0, "stalled pixel moved");
    check(sink.blank_bad, 0, "blanking level");
    $display("test stall done");
    ce <= 1'b0;
    cyc(8);
    check(vid_valid, 1'b0, "frozen stream");
    check(awready, 1'b0, "frozen bus");
    ce <= 1'b1;
    $display("test freeze done");
    results();
  end
endmodule: tb
